// >>> design/config_address_router.sv
`timescale 1ns/1ps
`include "cfg_router_regs.svh"

// Notes on behaviour
// - Non-zero bus outside bridge range: type 1 cycle on south hub link.
// - Non-zero bus equal to secondary bus: type 0 request on PCIe.
// - Bus above secondary, up to subordinate: type 1 request on PCIe.
// - Bus goes to header byte 8, or hub address 23:16 on type 1.
// - Bus zero: device 0, 1, 2 are host, PCIe bridge, graphics.
// - Device field bits 15:11 to header byte 6 7:3 or hub 15:11.
// - Internal device accesses with function above 1 are ignored.
// - Function goes to header byte 6 2:0 or hub address 10:8.
// - Register field 7:2 to header byte 7 7:2 or hub 7:2.
// - Address port bits 1:0 reserved, never select a register.
// - Enable set: data window access becomes config transaction.
// - Data window is 32-bit read/write at 0cfc, resets to zero.
// - Address port at 0cf8 claimed only for full doubleword access.
// - Enable resets to 0; config access only while enable is 1.
// - Bus zero, no internal device: type 0 cycle on south hub link.
// - Type 0 PCIe access to non-zero device is master-aborted.
module config_address_router (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Host I/O cycle
    input wire logic i_io_valid,
    input wire logic i_io_write,
    input wire logic [15:0] i_io_addr,
    input wire logic [3:0] i_io_be,
    input wire logic [31:0] i_io_wdata,
    output logic [31:0] o_io_rdata,
    output logic o_io_claimed,
    // Bridge bus window and enables
    input wire logic [7:0] i_sec_bus,
    input wire logic [7:0] i_sub_bus,
    input wire logic [2:0] i_dev_enable,
    // Routed request
    output cfg_router_pkg::cfg_req_t o_req
);
    // ----------------------------------------------------------
    // State
    // ----------------------------------------------------------
    cfg_router_pkg::router_state_t st_r;
    cfg_router_pkg::router_state_t st_nxt;
    cfg_router_pkg::target_t tgt;
    cfg_router_pkg::cfg_addr_t fld;
    logic type1;
    logic mabort;
    logic hit_addr;
    logic hit_data;
    logic cfg_en;

    cfg_decode u_decode (
        .i_addr_port(st_r.addr_port),
        .i_sec_bus(i_sec_bus),
        .i_sub_bus(i_sub_bus),
        .i_dev_enable(i_dev_enable),
        .o_target(tgt),
        .o_type1(type1),
        .o_mabort(mabort),
        .o_fields(fld)
    );

    assign cfg_en = st_r.addr_port[`CFG_EN_BIT];
    // Partial address port accesses fall through as plain I/O downstream
    assign hit_addr = i_io_valid && i_io_addr == `CFG_ADDR_PORT_IO
                      && i_io_be == `CFG_FULL_DWORD;
    assign hit_data = i_io_valid && i_io_addr == `CFG_DATA_WIN_IO;

    // ----------------------------------------------------------
    // Next state
    // ----------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.req.valid = 1'b0;
        if (hit_addr && i_io_write) begin
            // Reserved bits stay zero
            st_nxt.addr_port = i_io_wdata & `CFG_ADDR_WMASK;
        end
        if (hit_data && cfg_en) begin
            st_nxt.req.valid = 1'b1;
            st_nxt.req.target = tgt;
            st_nxt.req.type1 = type1;
            st_nxt.req.mabort = mabort;
            st_nxt.req.write = i_io_write;
            st_nxt.req.be = i_io_be;
            st_nxt.req.wdata = i_io_wdata;
            st_nxt.req.hdr_byte8 = fld.bus;
            st_nxt.req.hdr_byte6 = {fld.dev, fld.fn};
            st_nxt.req.hdr_byte7 = {fld.regn, 2'b00};
            // Bus bits only carried on hub type 1 cycles
            st_nxt.req.hub_addr = {(type1 ? fld.bus : `CFG_BUS_ZERO),
                                   fld.dev, fld.fn, fld.regn,
                                   2'b00};
            if (i_io_write) begin
                st_nxt.data_win = i_io_wdata;
            end
        end else if (hit_data) begin
            st_nxt.req.valid = 1'b1;
            st_nxt.req.target = cfg_router_pkg::TGT_IO;
            st_nxt.req.type1 = 1'b0;
            st_nxt.req.mabort = 1'b0;
            st_nxt.req.write = i_io_write;
            st_nxt.req.be = i_io_be;
            st_nxt.req.wdata = i_io_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
            st_r.req.target <= cfg_router_pkg::TGT_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------
    assign o_io_claimed = hit_addr || (hit_data && cfg_en);
    assign o_req = st_r.req;

    always_comb begin
        o_io_rdata = 32'h00000000;
        if (hit_addr) begin
            o_io_rdata = st_r.addr_port;
        end else if (hit_data && cfg_en) begin
            o_io_rdata = st_r.data_win;
        end
    end

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    // Window access while configuration space is enabled
    sequence s_data_hit_en;
        hit_data && cfg_en;
    endsequence

    // Window access while configuration space is disabled
    sequence s_data_hit_off;
        hit_data && !cfg_en;
    endsequence

    // Full doubleword write into the address port
    sequence s_addr_write;
        hit_addr && i_io_write;
    endsequence

    // Byte or word access at the address port
    sequence s_addr_partial;
        i_io_valid && i_io_addr == `CFG_ADDR_PORT_IO
        && i_io_be != `CFG_FULL_DWORD;
    endsequence

    a_cfg_req_issue: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en |=> o_req.valid
        && o_req.target != cfg_router_pkg::TGT_IO)
        else $error("config access not issued");
    a_req_payload: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en |=> o_req.write == $past(i_io_write)
        && o_req.be == $past(i_io_be) && o_req.wdata == $past(i_io_wdata))
        else $error("config request payload wrong");
    a_disabled_io: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_off |=> o_req.valid
        && o_req.target == cfg_router_pkg::TGT_IO)
        else $error("disabled window not plain I/O");
    a_disabled_free: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_off |-> !o_io_claimed)
        else $error("disabled window claimed");
    a_enable_gate: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !cfg_en |=> !o_req.valid
        || o_req.target == cfg_router_pkg::TGT_IO)
        else $error("config request while disabled");
    a_hub_type1: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en and (fld.bus != `CFG_BUS_ZERO
        && fld.bus != i_sec_bus
        && !(fld.bus > i_sec_bus && fld.bus <= i_sub_bus))
        |=> o_req.target == cfg_router_pkg::TGT_HUB && o_req.type1)
        else $error("hub type 1 misrouted");
    a_pcie_type0: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en and (fld.bus != `CFG_BUS_ZERO
        && fld.bus == i_sec_bus)
        |=> o_req.target == cfg_router_pkg::TGT_PCIE && !o_req.type1)
        else $error("pcie type 0 misrouted");
    a_pcie_type1: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en and (fld.bus != `CFG_BUS_ZERO
        && fld.bus > i_sec_bus && fld.bus <= i_sub_bus)
        |=> o_req.target == cfg_router_pkg::TGT_PCIE && o_req.type1)
        else $error("pcie type 1 misrouted");
    a_bus_byte8: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en |=> o_req.hdr_byte8
        == $past(st_r.addr_port[`CFG_BUS_HI:`CFG_BUS_LO]))
        else $error("bus field misplaced");
    a_hub_bus: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en and (tgt == cfg_router_pkg::TGT_HUB && type1)
        |=> o_req.hub_addr[`CFG_BUS_HI:`CFG_BUS_LO]
        == $past(st_r.addr_port[`CFG_BUS_HI:`CFG_BUS_LO]))
        else $error("hub bus bits misplaced");
    a_hdr_dev_fn: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en |=> o_req.hdr_byte6
        == $past(st_r.addr_port[`CFG_DEV_HI:`CFG_FN_LO]))
        else $error("device or function header misplaced");
    a_hdr_reg: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en |=> o_req.hdr_byte7[`CFG_REG_HI:`CFG_REG_LO]
        == $past(st_r.addr_port[`CFG_REG_HI:`CFG_REG_LO]))
        else $error("register header misplaced");
    a_hub_fields: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en |=> o_req.hub_addr[`CFG_DEV_HI:`CFG_REG_LO]
        == $past(st_r.addr_port[`CFG_DEV_HI:`CFG_REG_LO]))
        else $error("hub address fields misplaced");
    a_peg_claim: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en and (fld.bus == `CFG_BUS_ZERO
        && fld.fn <= `CFG_FN_MAX
        && fld.dev == `CFG_DEV_PEG && i_dev_enable[1])
        |=> o_req.target == cfg_router_pkg::TGT_PEG)
        else $error("express bridge not claimed");
    a_hub_type0: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en and (fld.bus == `CFG_BUS_ZERO
        && !(fld.dev == `CFG_DEV_HOST && i_dev_enable[0])
        && !(fld.dev == `CFG_DEV_PEG && i_dev_enable[1])
        && !(fld.dev == `CFG_DEV_GFX && i_dev_enable[2]))
        |=> o_req.target == cfg_router_pkg::TGT_HUB && !o_req.type1
        && o_req.hub_addr[`CFG_BUS_HI:`CFG_BUS_LO] == `CFG_BUS_ZERO)
        else $error("bus 0 hub type 0 misrouted");
    a_fn_ignore: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en and (fld.bus == `CFG_BUS_ZERO
        && fld.fn > `CFG_FN_MAX && tgt != cfg_router_pkg::TGT_HUB)
        |=> o_req.target == cfg_router_pkg::TGT_NONE)
        else $error("bad function not ignored");
    a_mabort_dev: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en and (tgt == cfg_router_pkg::TGT_PCIE && !type1
        && fld.dev != `CFG_DEV_HOST) |=> o_req.mabort)
        else $error("type 0 nonzero device not aborted");
    a_reserved_zero: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (st_r.addr_port & ~`CFG_ADDR_WMASK) == `CFG_ADDR_RST)
        else $error("reserved address bits set");
    a_addr_write: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_addr_write |=> st_r.addr_port
        == ($past(i_io_wdata) & `CFG_ADDR_WMASK))
        else $error("address port write lost");
    a_addr_claim: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        hit_addr |-> o_io_claimed && o_io_rdata == st_r.addr_port)
        else $error("address port access not claimed");
    a_partial_pass: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_addr_partial |-> !o_io_claimed
        ##1 st_r.addr_port == $past(st_r.addr_port))
        else $error("partial address access claimed");
    a_win_write: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en and i_io_write
        |=> st_r.data_win == $past(i_io_wdata))
        else $error("data window write lost");
    a_win_read: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_data_hit_en |-> o_io_claimed && o_io_rdata == st_r.data_win)
        else $error("data window read wrong");
endmodule

// >>> design/cfg_router_regs.svh
`ifndef CFG_ROUTER_REGS_SVH
`define CFG_ROUTER_REGS_SVH

// --------------------------------------------------------------
// I/O addresses
// --------------------------------------------------------------
`define CFG_ADDR_PORT_IO 16'h0cf8
`define CFG_DATA_WIN_IO 16'h0cfc
`define CFG_FULL_DWORD 4'hf

// --------------------------------------------------------------
// Address port fields
// --------------------------------------------------------------
`define CFG_EN_BIT 31
`define CFG_BUS_HI 23
`define CFG_BUS_LO 16
`define CFG_DEV_HI 15
`define CFG_DEV_LO 11
`define CFG_FN_HI 10
`define CFG_FN_LO 8
`define CFG_REG_HI 7
`define CFG_REG_LO 2
`define CFG_ADDR_WMASK 32'h80fffffc
`define CFG_ADDR_RST 32'h00000000
`define CFG_DATA_RST 32'h00000000

// --------------------------------------------------------------
// Decode constants
// --------------------------------------------------------------
`define CFG_BUS_ZERO 8'h00
`define CFG_DEV_HOST 5'h00
`define CFG_DEV_PEG 5'h01
`define CFG_DEV_GFX 5'h02
`define CFG_FN_MAX 3'h1

`endif

// >>> design/cfg_router_pkg.sv
package cfg_router_pkg;

    typedef enum logic [6:0] {
        TGT_NONE = 7'h01,
        TGT_HOST = 7'h02,
        TGT_PEG = 7'h04,
        TGT_GFX = 7'h08,
        TGT_PCIE = 7'h10,
        TGT_HUB = 7'h20,
        TGT_IO = 7'h40
    } target_t;

    typedef struct packed {
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] fn;
        logic [5:0] regn;
    } cfg_addr_t;

    typedef struct packed {
        logic valid;
        target_t target;
        logic type1;
        logic mabort;
        logic write;
        logic [7:0] hdr_byte6;
        logic [7:0] hdr_byte7;
        logic [7:0] hdr_byte8;
        logic [23:0] hub_addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } cfg_req_t;

    typedef struct packed {
        logic [31:0] addr_port;
        logic [31:0] data_win;
        cfg_req_t req;
    } router_state_t;

endpackage

// >>> design/cfg_decode.sv
`timescale 1ns/1ps
`include "cfg_router_regs.svh"

module cfg_decode (
    // Latched address
    input wire logic [31:0] i_addr_port,
    // Bridge bus window and enables
    input wire logic [7:0] i_sec_bus,
    input wire logic [7:0] i_sub_bus,
    input wire logic [2:0] i_dev_enable,
    // Decode result
    output cfg_router_pkg::target_t o_target,
    output logic o_type1,
    output logic o_mabort,
    output cfg_router_pkg::cfg_addr_t o_fields
);
    cfg_router_pkg::cfg_addr_t f;
    logic internal_dev;
    logic fn_ok;

    always_comb begin
        // Bits 1:0 never reach the register field
        f.bus = i_addr_port[`CFG_BUS_HI:`CFG_BUS_LO];
        f.dev = i_addr_port[`CFG_DEV_HI:`CFG_DEV_LO];
        f.fn = i_addr_port[`CFG_FN_HI:`CFG_FN_LO];
        f.regn = i_addr_port[`CFG_REG_HI:`CFG_REG_LO];
        fn_ok = (f.fn <= `CFG_FN_MAX);
        internal_dev = 1'b0;
        o_target = cfg_router_pkg::TGT_HUB;
        o_type1 = 1'b0;
        o_mabort = 1'b0;
        if (f.bus == `CFG_BUS_ZERO) begin
            case (f.dev)
                `CFG_DEV_HOST: internal_dev = i_dev_enable[0];
                `CFG_DEV_PEG: internal_dev = i_dev_enable[1];
                `CFG_DEV_GFX: internal_dev = i_dev_enable[2];
                default: internal_dev = 1'b0;
            endcase
            if (internal_dev) begin
                if (!fn_ok) begin
                    o_target = cfg_router_pkg::TGT_NONE;
                end else if (f.dev == `CFG_DEV_HOST) begin
                    o_target = cfg_router_pkg::TGT_HOST;
                end else if (f.dev == `CFG_DEV_PEG) begin
                    o_target = cfg_router_pkg::TGT_PEG;
                end else begin
                    o_target = cfg_router_pkg::TGT_GFX;
                end
            end else begin
                o_target = cfg_router_pkg::TGT_HUB;
            end
        end else if (f.bus == i_sec_bus) begin
            o_target = cfg_router_pkg::TGT_PCIE;
            o_mabort = (f.dev != `CFG_DEV_HOST);
        end else if (f.bus > i_sec_bus && f.bus <= i_sub_bus) begin
            o_target = cfg_router_pkg::TGT_PCIE;
            o_type1 = 1'b1;
        end else begin
            o_target = cfg_router_pkg::TGT_HUB;
            o_type1 = 1'b1;
        end
        o_fields = f;
    end
endmodule

// >>> tb/bridge_window_model.sv
`timescale 1ns/1ps

// ------------------------------------------
// Bridge bus window seen by the router
// ------------------------------------------
// Fixed numbers keep every route in the table predictable
module bridge_window_model #(
    parameter logic [7:0] SEC_BUS = 8'h01,
    parameter logic [7:0] SUB_BUS = 8'h03
) (
    // Bus window
    output logic [7:0] o_sec_bus,
    output logic [7:0] o_sub_bus
);
    assign o_sec_bus = SEC_BUS;
    assign o_sub_bus = SUB_BUS;
endmodule

// >>> tb/config_address_router_tb.sv
`timescale 1ns/1ps
`include "cfg_router_regs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end

module config_address_router_tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_io_valid = 1'b0;
    logic i_io_write = 1'b0;
    logic [15:0] i_io_addr = 16'h0000;
    logic [3:0] i_io_be = 4'h0;
    logic [31:0] i_io_wdata = 32'h00000000;
    logic [2:0] i_dev_enable = 3'h7;
    logic [31:0] o_io_rdata;
    logic o_io_claimed;
    logic [7:0] sec_bus;
    logic [7:0] sub_bus;
    cfg_router_pkg::cfg_req_t o_req;
    int failures = 0;
    int compares = 0;
    logic claimed;
    logic [31:0] rdata;

    always #2.5 i_clk = ~i_clk;

    config_address_router DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_io_valid(i_io_valid), .i_io_write(i_io_write),
        .i_io_addr(i_io_addr), .i_io_be(i_io_be), .i_io_wdata(i_io_wdata),
        .o_io_rdata(o_io_rdata), .o_io_claimed(o_io_claimed),
        .i_sec_bus(sec_bus), .i_sub_bus(sub_bus),
        .i_dev_enable(i_dev_enable), .o_req(o_req));

    bridge_window_model partner (.o_sec_bus(sec_bus), .o_sub_bus(sub_bus));

    // ------------------------------------------
    // Access tasks
    // ------------------------------------------
    // Claim and read data are combinational, so they are caught mid-cycle
    task automatic io(input logic wr, input logic [15:0] a,
            input logic [3:0] be, input logic [31:0] d);
        @(posedge i_clk);
        i_io_valid <= 1'b1;
        i_io_write <= wr;
        i_io_addr <= a;
        i_io_be <= be;
        i_io_wdata <= d;
        #1;
        claimed = o_io_claimed;
        rdata = o_io_rdata;
        @(posedge i_clk);
        i_io_valid <= 1'b0;
        #1;
    endtask

    task automatic route(input logic [31:0] a,
            input cfg_router_pkg::target_t t, input logic t1,
            input logic ma);
        io(1'b1, `CFG_ADDR_PORT_IO, `CFG_FULL_DWORD, a);
        io(1'b0, `CFG_DATA_WIN_IO, `CFG_FULL_DWORD, 32'h0);
        `CHK("claimed", 1'b1, claimed)
        `CHK("valid", 1'b1, o_req.valid)
        `CHK("target", t, o_req.target)
        `CHK("mabort", ma, o_req.mabort)
        `CHK("be", `CFG_FULL_DWORD, o_req.be)
        `CHK("write", 1'b0, o_req.write)
        if (t == cfg_router_pkg::TGT_PCIE) begin
            `CHK("type1", t1, o_req.type1)
            `CHK("byte6", a[15:8], o_req.hdr_byte6)
            `CHK("byte7", {a[7:2], 2'b00}, o_req.hdr_byte7)
            `CHK("byte8", a[23:16], o_req.hdr_byte8)
        end
        if (t == cfg_router_pkg::TGT_HUB) begin
            `CHK("type1", t1, o_req.type1)
            `CHK("hub", {t1 ? a[23:16] : 8'h00, a[15:2], 2'b00},
                o_req.hub_addr)
        end
        @(posedge i_clk);
        #1;
        `CHK("valid end", 1'b0, o_req.valid)
    endtask

    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------
    // Tests
    // ------------------------------------------
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        io(1'b0, `CFG_ADDR_PORT_IO, `CFG_FULL_DWORD, 32'h0);
        `CHK("addr rst", 32'h0, rdata)
        io(1'b0, `CFG_DATA_WIN_IO, `CFG_FULL_DWORD, 32'h0);
        `CHK("win off", 1'b0, claimed)
        `CHK("off rdata", 32'h0, rdata)
        `CHK("io valid", 1'b1, o_req.valid)
        `CHK("io tgt", cfg_router_pkg::TGT_IO, o_req.target)
        $display("test reset done");
        io(1'b1, `CFG_ADDR_PORT_IO, 4'h3, 32'h80010000);
        `CHK("part claim", 1'b0, claimed)
        io(1'b0, `CFG_ADDR_PORT_IO, `CFG_FULL_DWORD, 32'h0);
        `CHK("part kept", 32'h0, rdata)
        io(1'b1, `CFG_ADDR_PORT_IO, `CFG_FULL_DWORD, 32'hffffffff);
        io(1'b0, `CFG_ADDR_PORT_IO, `CFG_FULL_DWORD, 32'h0);
        `CHK("addr mask", 32'h80fffffc, rdata)
        io(1'b1, `CFG_ADDR_PORT_IO, `CFG_FULL_DWORD, 32'h80000000);
        io(1'b0, `CFG_DATA_WIN_IO, `CFG_FULL_DWORD, 32'h0);
        `CHK("win rst", 32'h0, rdata)
        io(1'b1, `CFG_DATA_WIN_IO, `CFG_FULL_DWORD, 32'h12345678);
        `CHK("wr", 1'b1, o_req.write)
        `CHK("wdata", 32'h12345678, o_req.wdata)
        io(1'b0, `CFG_DATA_WIN_IO, `CFG_FULL_DWORD, 32'h0);
        `CHK("win rd", 32'h12345678, rdata)
        $display("test registers done");
        route(32'h80000000, cfg_router_pkg::TGT_HOST, 1'b0, 1'b0);
        route(32'h80000800, cfg_router_pkg::TGT_PEG, 1'b0, 1'b0);
        route(32'h80001000, cfg_router_pkg::TGT_GFX, 1'b0, 1'b0);
        route(32'h80000200, cfg_router_pkg::TGT_NONE, 1'b0, 1'b0);
        route(32'h80002800, cfg_router_pkg::TGT_HUB, 1'b0, 1'b0);
        route(32'h80010104, cfg_router_pkg::TGT_PCIE, 1'b0, 1'b0);
        route(32'h80011800, cfg_router_pkg::TGT_PCIE, 1'b0, 1'b1);
        route(32'h8003f9fc, cfg_router_pkg::TGT_PCIE, 1'b1, 1'b0);
        route(32'h80043a5b, cfg_router_pkg::TGT_HUB, 1'b1, 1'b0);
        route(32'h80ff0000, cfg_router_pkg::TGT_HUB, 1'b1, 1'b0);
        @(posedge i_clk);
        i_dev_enable <= 3'b101;
        route(32'h80000800, cfg_router_pkg::TGT_HUB, 1'b0, 1'b0);
        $display("test routes done");
        end_of_test();
    end

    // Whole run needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge i_clk);
        failures++;
        end_of_test();
    end
endmodule
